// >>> pkg/hbw_pkg.sv
package hbw_pkg;

   // Data path widths of the host port.
   localparam int unsigned BUS_W     = 32;
   localparam int unsigned HALF_W    = 16;
   // The byte address on the pins is A[ADDR_W-1:1]; A[1] picks the halfword.
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned DW_ADDR_W = ADDR_W - 2;

   // Bus width indication in the hardware configuration register.
   localparam int unsigned HWCFG_WIDTH_BIT = 2;
   // Strap level on the serial ROM data pin that selects the 32-bit bus.
   localparam logic        STRAP_BUS32     = 1'h1;

   // Swap control value that turns the halfword mapping round.
   localparam logic [BUS_W-1:0] SWAP_ALL_ONES = 32'hffffffff;

   // Values after reset.
   localparam logic [BUS_W-1:0]     RST_WORD  = 32'h00000000;
   localparam logic [DW_ADDR_W-1:0] RST_DWADR = 6'h00;
   localparam logic [1:0]           OE_OFF_N  = 2'h3;

   // Halfword pairing state.
   typedef enum logic {
      TRK_IDLE,
      TRK_HALF
   } hbw_track_e;

endpackage : hbw_pkg

// >>> rtl/hbw_half_pair.sv
`timescale 1ns/1ps

module hbw_half_pair (
   input  wire logic                           clock,
   input  wire logic                           reset,
   input  wire logic                           accValid,
   input  wire logic                           accWrite,
   input  wire logic [hbw_pkg::DW_ADDR_W-1:0]  accAddr,
   input  wire logic                           accHigh,
   output logic                                isFirst,
   output logic                                isSecond,
   output logic                                isCollide,
   output logic                                pending
);

   hbw_pkg::hbw_track_e               state_q;
   hbw_pkg::hbw_track_e               state_d;
   logic                              pendWrite_q;
   logic                              pendWrite_d;
   logic                              pendHigh_q;
   logic                              pendHigh_d;
   logic [hbw_pkg::DW_ADDR_W-1:0]     pendAddr_q;
   logic [hbw_pkg::DW_ADDR_W-1:0]     pendAddr_d;
   logic                              sameDword;

   assign pending   = (state_q == hbw_pkg::TRK_HALF);
   // A new address or a change of direction starts a new DWORD.
   assign sameDword = pending && (accAddr == pendAddr_q) && (accWrite == pendWrite_q); // R13
   assign isSecond  = accValid && sameDword && (accHigh != pendHigh_q);                 // R04
   assign isCollide = accValid && sameDword && (accHigh == pendHigh_q);                 // R05 R07
   assign isFirst   = accValid && !sameDword;

   always_comb begin
      state_d     = state_q;
      pendWrite_d = pendWrite_q;
      pendHigh_d  = pendHigh_q;
      pendAddr_d  = pendAddr_q;
      if (isFirst) begin
         state_d     = hbw_pkg::TRK_HALF;
         pendWrite_d = accWrite;
         pendHigh_d  = accHigh;
         pendAddr_d  = accAddr;
      end else if (isSecond || isCollide) begin
         state_d = hbw_pkg::TRK_IDLE; // R07
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_q     <= hbw_pkg::TRK_IDLE;
         pendWrite_q <= 1'h0;
         pendHigh_q  <= 1'h0;
         pendAddr_q  <= hbw_pkg::RST_DWADR;
      end else begin
         state_q     <= state_d;
         pendWrite_q <= pendWrite_d;
         pendHigh_q  <= pendHigh_d;
         pendAddr_q  <= pendAddr_d;
      end
   end

endmodule : hbw_half_pair

// >>> rtl/hbw_host_port.sv
`timescale 1ns/1ps

// Operation
// R01 - Bus width comes from the serial ROM pin strap; reported in config bit 2.
// R02 - In 32-bit mode each bus cycle is one whole DWORD access.
// R03 - In 16-bit mode the host writes both halves back to back, same DWORD.
// R04 - Halves may arrive in either order; commit when the other half arrives.
// R05 - A second write to the same half discards the whole transfer.
// R06 - In 16-bit mode the host reads both halves consecutively, same DWORD.
// R07 - Same-half reads give invalid data; tracking restarts; host reads again.
// R08 - In 16-bit mode the upper sixteen data lines are never driven.
// R09 - Without all-ones swap, A1=0 is the low half, A1=1 the high half.
// R10 - With all-ones swap, A1=0 is the high half, A1=1 the low half.
// R11 - In 32-bit mode swap is ignored; D[31:16] high, D[15:0] low.
// R12 - Halves land in fixed DWORD positions, so either half may go first.
// R13 - An address change mid-pair drops the first half and starts afresh.

module hbw_host_port (
   input  wire logic                           clock,
   input  wire logic                           reset,
   input  wire logic                           serialRomDataPin,
   input  wire logic                           busCs_n,
   input  wire logic                           busRd_n,
   input  wire logic                           busWr_n,
   input  wire logic [hbw_pkg::ADDR_W-1:1]     busAddr,
   input  wire logic [hbw_pkg::BUS_W-1:0]      dataIn,
   output logic      [hbw_pkg::BUS_W-1:0]      dataOut,
   output logic      [1:0]                     dataOe_n,
   input  wire logic [hbw_pkg::BUS_W-1:0]      wordSwapCtrl,
   output logic      [hbw_pkg::BUS_W-1:0]      hardwareConfigRegister,
   output logic                                intWrValid,
   output logic      [hbw_pkg::DW_ADDR_W-1:0]  intWrAddr,
   output logic      [hbw_pkg::BUS_W-1:0]      intWrData,
   output logic                                intRdReq,
   output logic      [hbw_pkg::DW_ADDR_W-1:0]  intRdAddr,
   input  wire logic [hbw_pkg::BUS_W-1:0]      intRdData,
   output logic                                rdRetry,
   output logic                                wrDiscard
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Halfword helpers.

   function automatic logic [hbw_pkg::HALF_W-1:0] pickHalf(input logic [hbw_pkg::BUS_W-1:0] word,
                                                          input logic                      high);
      pickHalf = high ? word[hbw_pkg::BUS_W-1:hbw_pkg::HALF_W] : word[hbw_pkg::HALF_W-1:0];
   endfunction : pickHalf

   function automatic logic [hbw_pkg::BUS_W-1:0] putHalf(input logic [hbw_pkg::BUS_W-1:0]  word,
                                                        input logic [hbw_pkg::HALF_W-1:0] half,
                                                        input logic                       high);
      putHalf = high ? {half, word[hbw_pkg::HALF_W-1:0]} : {word[hbw_pkg::BUS_W-1:hbw_pkg::HALF_W], half};
   endfunction : putHalf

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Strap capture and mode.

   logic                          strapDone_q;
   logic                          strapDone_d;
   logic                          bus32_q;
   logic                          bus32_d;
   logic                          mode16;
   logic                          swapOn;
   logic                          logicalHigh;

   // The strap is caught in the first cycle after reset is released.
   always_comb begin
      strapDone_d = 1'h1;
      bus32_d     = bus32_q;
      if (!strapDone_q) begin
         bus32_d = (serialRomDataPin == hbw_pkg::STRAP_BUS32); // R01
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         strapDone_q <= 1'h0;
         bus32_q     <= 1'h0;
      end else begin
         strapDone_q <= strapDone_d;
         bus32_q     <= bus32_d;
      end
   end

   always_comb begin
      hardwareConfigRegister                          = hbw_pkg::RST_WORD;
      hardwareConfigRegister[hbw_pkg::HWCFG_WIDTH_BIT] = bus32_q; // R01
   end

   assign mode16      = strapDone_q && !bus32_q;
   assign swapOn      = (wordSwapCtrl == hbw_pkg::SWAP_ALL_ONES); // R10
   assign logicalHigh = busAddr[1] ^ swapOn;                     // R09 R10

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Strobe edges.

   logic                          rdAct;
   logic                          wrAct;
   logic                          rdActPrev_q;
   logic                          wrActPrev_q;
   logic                          rdStart;
   logic                          wrStart;
   logic [hbw_pkg::DW_ADDR_W-1:0] dwAddr;

   assign rdAct   = !busCs_n && !busRd_n;
   assign wrAct   = !busCs_n && !busWr_n;
   assign wrStart = strapDone_q && wrAct && !wrActPrev_q;
   assign rdStart = strapDone_q && rdAct && !rdActPrev_q && !wrAct;
   assign dwAddr  = busAddr[hbw_pkg::ADDR_W-1:2];

   always_ff @(posedge clock) begin
      if (reset) begin
         rdActPrev_q <= 1'h0;
         wrActPrev_q <= 1'h0;
      end else begin
         rdActPrev_q <= rdAct;
         wrActPrev_q <= wrAct;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Halfword pairing for 16-bit mode.

   logic                          pairFirst;
   logic                          pairSecond;
   logic                          pairCollide;
   logic                          pairPending;

   hbw_half_pair u_pair (
      .clock     (clock),
      .reset     (reset),
      .accValid  (mode16 && (wrStart || rdStart)),
      .accWrite  (wrStart),
      .accAddr   (dwAddr),
      .accHigh   (logicalHigh),
      .isFirst   (pairFirst),
      .isSecond  (pairSecond),
      .isCollide (pairCollide),
      .pending   (pairPending)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Write path.

   logic [hbw_pkg::BUS_W-1:0]     wrBuf_q;
   logic [hbw_pkg::BUS_W-1:0]     wrBuf_d;
   logic                          intWrValid_q;
   logic                          intWrValid_d;
   logic [hbw_pkg::DW_ADDR_W-1:0] intWrAddr_q;
   logic [hbw_pkg::DW_ADDR_W-1:0] intWrAddr_d;
   logic [hbw_pkg::BUS_W-1:0]     intWrData_q;
   logic [hbw_pkg::BUS_W-1:0]     intWrData_d;
   logic                          wrDiscard_q;
   logic                          wrDiscard_d;

   always_comb begin
      wrBuf_d      = wrBuf_q;
      intWrValid_d = 1'h0;
      intWrAddr_d  = intWrAddr_q;
      intWrData_d  = intWrData_q;
      wrDiscard_d  = 1'h0;
      if (wrStart && !mode16) begin
         intWrValid_d = 1'h1; // R02
         intWrAddr_d  = dwAddr;
         intWrData_d  = dataIn; // R11
      end else if (wrStart && pairFirst) begin
         wrBuf_d = putHalf(wrBuf_q, dataIn[hbw_pkg::HALF_W-1:0], logicalHigh);
      end else if (wrStart && pairSecond) begin
         intWrValid_d = 1'h1; // R04
         intWrAddr_d  = dwAddr;
         intWrData_d  = putHalf(wrBuf_q, dataIn[hbw_pkg::HALF_W-1:0], logicalHigh); // R12
      end else if (wrStart && pairCollide) begin
         wrDiscard_d = 1'h1; // R05
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         wrBuf_q      <= hbw_pkg::RST_WORD;
         intWrValid_q <= 1'h0;
         intWrAddr_q  <= hbw_pkg::RST_DWADR;
         intWrData_q  <= hbw_pkg::RST_WORD;
         wrDiscard_q  <= 1'h0;
      end else begin
         wrBuf_q      <= wrBuf_d;
         intWrValid_q <= intWrValid_d;
         intWrAddr_q  <= intWrAddr_d;
         intWrData_q  <= intWrData_d;
         wrDiscard_q  <= wrDiscard_d;
      end
   end

   assign intWrValid = intWrValid_q;
   assign intWrAddr  = intWrAddr_q;
   assign intWrData  = intWrData_q;
   assign wrDiscard  = wrDiscard_q;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Read path. Only the first half of a pair reads inside, so a FIFO pops once per DWORD.

   logic [hbw_pkg::BUS_W-1:0]     rdBuf_q;
   logic [hbw_pkg::BUS_W-1:0]     rdBuf_d;
   logic [hbw_pkg::BUS_W-1:0]     dataOut_q;
   logic [hbw_pkg::BUS_W-1:0]     dataOut_d;
   logic                          rdRetry_q;
   logic                          rdRetry_d;

   assign intRdReq  = rdStart && (!mode16 || pairFirst);
   assign intRdAddr = dwAddr;

   always_comb begin
      rdBuf_d   = rdBuf_q;
      dataOut_d = dataOut_q;
      rdRetry_d = 1'h0;
      if (rdStart && !mode16) begin
         dataOut_d = intRdData; // R02 R11
      end else if (rdStart && pairFirst) begin
         rdBuf_d   = intRdData;
         dataOut_d = {{hbw_pkg::HALF_W{1'b0}}, pickHalf(intRdData, logicalHigh)}; // R09 R10
      end else if (rdStart && pairSecond) begin
         dataOut_d = {{hbw_pkg::HALF_W{1'b0}}, pickHalf(rdBuf_q, logicalHigh)};
      end else if (rdStart && pairCollide) begin
         dataOut_d = {{hbw_pkg::HALF_W{1'b0}}, pickHalf(rdBuf_q, logicalHigh)};
         rdRetry_d = 1'h1; // R07
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         rdBuf_q   <= hbw_pkg::RST_WORD;
         dataOut_q <= hbw_pkg::RST_WORD;
         rdRetry_q <= 1'h0;
      end else begin
         rdBuf_q   <= rdBuf_d;
         dataOut_q <= dataOut_d;
         rdRetry_q <= rdRetry_d;
      end
   end

   assign dataOut     = dataOut_q;
   assign rdRetry     = rdRetry_q;
   assign dataOe_n[0] = !(strapDone_q && rdAct);
   assign dataOe_n[1] = !(strapDone_q && rdAct && bus32_q); // R08

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Checks.

   strap_stable_a: assert property (@(posedge clock) disable iff (reset) // R01
      strapDone_q && $past(strapDone_q) |-> $stable(bus32_q) &&
      hardwareConfigRegister[hbw_pkg::HWCFG_WIDTH_BIT] == bus32_q)
      else $error("Bus width changed after capture.");

   full_word_a: assert property (@(posedge clock) disable iff (reset) // R02
      wrStart && !mode16 |=> intWrValid && intWrData == $past(dataIn) && intWrAddr == $past(dwAddr))
      else $error("32-bit write not committed whole.");

   first_half_a: assert property (@(posedge clock) disable iff (reset) // R04
      wrStart && mode16 && pairFirst |=> !intWrValid && pairPending)
      else $error("First half committed alone.");

   pair_commit_a: assert property (@(posedge clock) disable iff (reset) // R04
      wrStart && pairSecond |=> intWrValid && intWrAddr == $past(dwAddr) && !pairPending)
      else $error("Completed write pair not committed.");

   wr_discard_a: assert property (@(posedge clock) disable iff (reset) // R05
      wrStart && pairCollide |=> !intWrValid && wrDiscard && !pairPending)
      else $error("Same-half write not discarded.");

   rd_retry_a: assert property (@(posedge clock) disable iff (reset) // R07
      rdStart && pairCollide && !intRdReq |=> rdRetry && !pairPending)
      else $error("Same-half read did not restart tracking.");

   upper_float_a: assert property (@(posedge clock) disable iff (reset) // R08
      mode16 |-> dataOe_n[1] && dataOut[31:16] == 16'h0000)
      else $error("Upper data lines driven in 16-bit mode.");

   normal_map_a: assert property (@(posedge clock) disable iff (reset) // R09
      rdStart && pairFirst && !swapOn |=> dataOut[15:0] == ($past(busAddr[1]) ? $past(intRdData[31:16])
                                                                              : $past(intRdData[15:0])))
      else $error("Unswapped halfword mapping wrong.");

   swap_map_a: assert property (@(posedge clock) disable iff (reset) // R10
      rdStart && pairFirst && swapOn |=> dataOut[15:0] == ($past(busAddr[1]) ? $past(intRdData[15:0])
                                                                             : $past(intRdData[31:16])))
      else $error("Swapped halfword mapping wrong.");

   wide_read_a: assert property (@(posedge clock) disable iff (reset) // R11
      rdStart && !mode16 |-> intRdReq ##1 dataOut == $past(intRdData))
      else $error("32-bit read data wrong.");

   low_place_a: assert property (@(posedge clock) disable iff (reset) // R12
      wrStart && pairSecond && !logicalHigh |=> intWrData[15:0] == $past(dataIn[15:0]))
      else $error("Low half not placed in low DWORD position.");

   addr_change_a: assert property (@(posedge clock) disable iff (reset) // R13
      wrStart && mode16 && pairPending && pairFirst |=> !intWrValid && pairPending)
      else $error("Half from another DWORD completed a pair.");

endmodule : hbw_host_port

// >>> testbench/hbw_host_model.sv
`timescale 1ns/1ps

module hbw_host_model (
   input  wire logic [hbw_pkg::BUS_W-1:0] busData,
   input  wire logic [1:0]                dataOe_n,
   input  wire logic                      clock,
   output logic                           busCs_n,
   output logic                           busRd_n,
   output logic                           busWr_n,
   output logic      [hbw_pkg::ADDR_W-1:1] busAddr,
   output logic      [hbw_pkg::BUS_W-1:0] hostData
);

   initial begin
      busCs_n  = 1'h1;
      busRd_n  = 1'h1;
      busWr_n  = 1'h1;
      busAddr  = 7'h00;
      hostData = 32'h00000000;
   end

   // One bus cycle entered at a falling edge; the strobes then stay high for a full cycle.
   task automatic access(input logic wr, input logic [hbw_pkg::ADDR_W-1:1] a,
                         input logic [hbw_pkg::BUS_W-1:0] d,
                         output logic [hbw_pkg::BUS_W-1:0] q, output logic [1:0] oe);
      busAddr = a;
      busCs_n = 1'h0;
      busWr_n = !wr;
      busRd_n = wr;
      if (wr) begin
         hostData = d;
      end
      @(posedge clock);
      @(negedge clock);
      q       = busData;
      oe      = dataOe_n;
      busCs_n = 1'h1;
      busWr_n = 1'h1;
      busRd_n = 1'h1;
      // Released lines show the inverse of their last value, never a held copy.
      hostData = ~hostData;
      busAddr  = ~a;
      @(negedge clock);
   endtask : access

endmodule : hbw_host_model

// >>> testbench/host_bus_width_swap_port_test.sv
`timescale 1ns/1ps

module host_bus_width_swap_port_test;

   typedef logic [hbw_pkg::BUS_W-1:0]     hbw_word_t;
   typedef logic [hbw_pkg::ADDR_W-1:1]    hbw_adr_t;
   typedef logic [hbw_pkg::DW_ADDR_W-1:0] hbw_dw_t;
   typedef struct packed {
      hbw_word_t swap;
      logic      a1;
      hbw_dw_t   adr;
      hbw_word_t exp;
   } hbw_row_s;

   logic      clock = 1'h0;
   logic      reset = 1'h1;
   logic      strap = 1'h0;
   logic      busCs_n, busRd_n, busWr_n, intWrValid, intRdReq, rdRetry, wrDiscard, h, sw;
   hbw_adr_t  busAddr;
   hbw_word_t hostData, busData, dataOut, hwCfg, intWrData, intRdData, q, w, lastWr;
   hbw_word_t wordSwapCtrl = 32'h00000000;
   hbw_dw_t   intWrAddr, intRdAddr, lastWrA;
   logic [1:0] dataOe_n, oe;
   int        error_cnt = 0;
   int        tests_run = 0;
   int        wrN = 0;
   int        discN = 0;
   int        retryN = 0;
   int        reqN = 0;
   int        n, m;

   hbw_row_s rows [5] = '{
      '{32'h00000000, 1'h0, 6'h05, 32'h1234abcd},
      '{32'h00000000, 1'h1, 6'h0a, 32'habcd1234},
      '{32'hffffffff, 1'h0, 6'h11, 32'habcd1234},
      '{32'hffffffff, 1'h1, 6'h2e, 32'h1234abcd},
      '{32'h0fffffff, 1'h1, 6'h3f, 32'habcd1234}};

   always #2 clock = ~clock;

   function automatic hbw_word_t rdw(input hbw_dw_t a);
      return {10'h300, a, 10'h0c0, a};
   endfunction : rdw

   // Upper lines have pull-downs, so in 16-bit mode they read low when nobody drives them.
   assign busData   = {dataOe_n[1] ? (strap ? hostData[31:16] : 16'h0000) : dataOut[31:16],
                       dataOe_n[0] ? hostData[15:0] : dataOut[15:0]};
   assign intRdData = rdw(intRdAddr);

   hbw_host_model host (.busData(busData), .dataOe_n(dataOe_n), .clock(clock), .busCs_n(busCs_n),
      .busRd_n(busRd_n), .busWr_n(busWr_n), .busAddr(busAddr), .hostData(hostData));

   hbw_host_port dut (.clock(clock), .reset(reset), .serialRomDataPin(strap), .busCs_n(busCs_n),
      .busRd_n(busRd_n), .busWr_n(busWr_n), .busAddr(busAddr), .dataIn(busData), .dataOut(dataOut),
      .dataOe_n(dataOe_n), .wordSwapCtrl(wordSwapCtrl), .hardwareConfigRegister(hwCfg),
      .intWrValid(intWrValid), .intWrAddr(intWrAddr), .intWrData(intWrData), .intRdReq(intRdReq),
      .intRdAddr(intRdAddr), .intRdData(intRdData), .rdRetry(rdRetry), .wrDiscard(wrDiscard));

   always @(posedge clock) begin
      if (intWrValid === 1'h1) begin
         wrN++;
         lastWr  = intWrData;
         lastWrA = intWrAddr;
      end
      if (wrDiscard === 1'h1) discN++;
      if (rdRetry === 1'h1) retryN++;
      if (intRdReq === 1'h1) reqN++;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input hbw_word_t e, input hbw_word_t g);
      tests_run++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask : chk

   task automatic wr(input hbw_adr_t a, input hbw_word_t d);
      host.access(1'h1, a, d, q, oe);
   endtask : wr

   task automatic rd(input hbw_adr_t a);
      host.access(1'h0, a, 32'h00000000, q, oe);
   endtask : rd

   task automatic boot(input logic s);
      strap = s;
      reset = 1'h1;
      repeat (12) @(negedge clock);
      reset = 1'h0;
      repeat (2) @(negedge clock);
   endtask : boot

   task automatic results();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results

   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3000) @(posedge clock);
      error_cnt++;
      $display("ERROR watchdog expected finish seen hang");
      results();
   end

   initial begin
      boot(1'h0);
      chk("width bit", 32'h00000000, hwCfg);
      chk("idle enable", 32'h00000003, dataOe_n);
      foreach (rows[i]) begin
         wordSwapCtrl = rows[i].swap;
         n = wrN;
         wr({rows[i].adr, rows[i].a1}, 32'h0000abcd);
         chk("early commit", n, wrN);
         wr({rows[i].adr, !rows[i].a1}, 32'h00001234);
         chk("commit count", n + 1, wrN);
         chk("commit data", rows[i].exp, lastWr);
         chk("commit addr", rows[i].adr, lastWrA);
         n  = reqN;
         sw = (rows[i].swap === 32'hffffffff);
         w  = rdw(rows[i].adr);
         for (int k = 0; k < 2; k++) begin
            h = rows[i].a1 ^ k[0];
            rd({rows[i].adr, h});
            chk("read half", {16'h0000, (h ^ sw) ? w[31:16] : w[15:0]}, q);
            chk("upper enable", 32'h00000002, oe);
         end
         chk("fetch count", n + 1, reqN);
      end
      wordSwapCtrl = 32'h00000000;
      n = wrN;
      m = discN;
      wr({6'h07, 1'h0}, 32'h00001111);
      wr({6'h07, 1'h0}, 32'h00002222);
      chk("same half discard", m + 1, discN);
      wr({6'h07, 1'h1}, 32'h00003333);
      wr({6'h09, 1'h0}, 32'h00005555);
      wr({6'h0b, 1'h1}, 32'h00006666);
      wr({6'h0b, 1'h0}, 32'h00007777);
      chk("restart count", n + 1, wrN);
      chk("restart data", 32'h66667777, lastWr);
      chk("restart addr", 32'h0000000b, lastWrA);
      m = retryN;
      n = reqN;
      rd({6'h0c, 1'h0});
      rd({6'h0c, 1'h0});
      chk("retry pulse", m + 1, retryN);
      rd({6'h0c, 1'h1});
      rd({6'h0c, 1'h0});
      w = rdw(6'h0c);
      chk("reread data", {16'h0000, w[15:0]}, q);
      chk("reread fetch", n + 2, reqN);
      boot(1'h1);
      chk("width bit", 32'h1 << hbw_pkg::HWCFG_WIDTH_BIT, hwCfg);
      wordSwapCtrl = 32'hffffffff;
      n = wrN;
      wr({6'h15, 1'h0}, 32'hdeadbeef);
      chk("wide commit", n + 1, wrN);
      chk("wide data", 32'hdeadbeef, lastWr);
      wr({6'h15, 1'h1}, 32'h01234567);
      chk("wide again", n + 2, wrN);
      chk("wide data", 32'h01234567, lastWr);
      m = reqN;
      rd({6'h16, 1'h1});
      chk("wide read", rdw(6'h16), q);
      chk("wide enable", 32'h00000000, oe);
      chk("wide fetch", m + 1, reqN);
      results();
   end

endmodule : host_bus_width_swap_port_test
